// [output_turn_on_off_sequencer.sv]
// turn-on/turn-off sequencer with setpoint decode and load line
// assumes commands, current reading and zero flag are on clock domain
`timescale 1ns/1ps
// Summary of operation
// - 256 setpoint codes span full output range
// - sub-ranges step 12.5, 25, 50 mV
// - nonzero load regulation droops output with current
// - delay and ramp registers host writable
// - turn-on delay ends when ramp up starts
// - turn-on code gives delay in ms
// - upper two turn-off bits read zero
// - with slew, delay ends at zero output
// - with slew, wait delay minus ramp time
// - without slew, switches off at delay end
// - without slew, decay left to load
// - registers return to defaults on power-up
module output_turn_on_off_sequencer #(
    parameter int ms_cycles = seq_pkg::tick_cycles
) (
    input  wire logic                      clock,
    input  wire logic                      rst,
    input  wire logic [7:0]                reg_addr,
    input  wire logic [7:0]                reg_wdata,
    input  wire logic                      reg_wr,
    output logic      [7:0]                reg_rdata,
    input  wire logic                      turn_on_cmd,
    input  wire logic                      turn_off_cmd,
    input  wire logic [7:0]                iout_meas,
    input  wire logic                      vout_at_zero,
    output logic      [seq_pkg::vout_w-1:0] vout_target,
    output logic                           ramp_up_start,
    output logic                           ramp_down_start,
    output logic                           switches_off,
    output logic                           seq_busy
);
    import seq_pkg::*;

    logic [7:0]  ramp_rate_config;       // slew enable and rates
    logic [7:0]  turn_on_delay;          // turn-on delay, ms
    logic [5:0]  turn_off_delay_field;   // turn-off delay, ms
    logic [7:0]  setpoint;               // output setpoint code
    logic [7:0]  current_limit_setting;  // load-line slope lives here
    seq_state_t  state_reg;              // sequencer state
    logic [7:0]  elapsed_reg;            // ms since last command
    logic [7:0]  target_reg;             // ms to wait in this phase
    logic        slew_reg;               // slew mode latched at turn-off
    logic [13:0] vset;                   // decoded setpoint
    logic [13:0] droop;                  // load-line offset
    logic [7:0]  ramp_ms;                // falling ramp length, ms
    logic [7:0]  pre_wait;               // wait before ramping down
    logic        take_on;                // turn-on accepted
    logic        take_off;               // turn-off accepted
    logic        expired;                // phase wait done
    tick_if      tk ();

    // setpoint code to 0.5 mV units over three resolutions
    function automatic logic [13:0] decode_vout(input logic [7:0] c);
        logic [13:0] cw;
        cw = {6'h00, c};
        if (c <= sub1_last) begin
            decode_vout = sub1_base + 14'(cw * step_fine);
        end else if (c <= sub2_last) begin
            decode_vout = sub2_base
                        + 14'((cw - 14'(sub1_last)) * step_mid);
        end else begin
            decode_vout = sub3_base
                        + 14'((cw - 14'(sub2_last)) * step_coarse);
        end
    endfunction

    // every one of the 256 codes maps to a distinct level
    assign vset = decode_vout(setpoint);

    // droop grows with measured current times programmed slope
    assign droop = 14'(iout_meas * current_limit_setting[load_reg_lsb +: 4]);

    // ramp time rounded up so the ramp never overruns a delay of at least ramp_ms
    assign ramp_ms = 8'((15'(vset) + fall_rate_tab[
        ramp_rate_config[fall_rate_lsb +: 3]] - 15'h0001)
        / fall_rate_tab[ramp_rate_config[fall_rate_lsb +: 3]]);

    // saturates at zero; a too-short delay is the host's to avoid
    assign pre_wait = ({2'b00, turn_off_delay_field} > ramp_ms) ?
        ({2'b00, turn_off_delay_field} - ramp_ms) : 8'h00;

    // off wins a tie; on is ignored while already regulating
    assign take_off = turn_off_cmd &&
                      (state_reg inside {st_on_wait, st_on});
    assign take_on  = turn_on_cmd && !take_off && (state_reg != st_on);
    assign expired  = (elapsed_reg >= target_reg);

    // register writes; reset restores all defaults
    always_ff @(posedge clock) begin
        if (rst) begin
            ramp_rate_config      <= ramp_rate_config_rst;
            turn_on_delay         <= turn_on_delay_rst;
            turn_off_delay_field  <= turn_off_delay_rst;
            setpoint              <= setpoint_rst;
            current_limit_setting <= current_limit_setting_rst;
        end else if (reg_wr) begin
            unique case (reg_addr)
                ramp_rate_config_off:      ramp_rate_config <= reg_wdata;
                turn_on_delay_off:         turn_on_delay <= reg_wdata;
                turn_off_delay_off:
                    turn_off_delay_field <= reg_wdata[off_field_w-1:0];
                setpoint_off:              setpoint <= reg_wdata;
                current_limit_setting_off:
                    current_limit_setting <= reg_wdata;
                default: ;  // unmapped writes are dropped
            endcase
        end
    end

    // registered read data, unmapped offsets read zero
    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            unique case (reg_addr)
                ramp_rate_config_off:      reg_rdata <= ramp_rate_config;
                turn_on_delay_off:         reg_rdata <= turn_on_delay;
                turn_off_delay_off:
                    reg_rdata <= {2'b00, turn_off_delay_field};
                setpoint_off:              reg_rdata <= setpoint;
                current_limit_setting_off:
                    reg_rdata <= current_limit_setting;
                default:                   reg_rdata <= 8'h00;
            endcase
        end
    end

    // millisecond divider, realigned on each accepted command
    assign tk.restart = take_on || take_off;
    ms_tick_gen #(.cycles(ms_cycles)) u_tick (
        .clock (clock),
        .rst   (rst),
        .tk    (tk)
    );

    // elapsed ms in the current phase, saturating
    always_ff @(posedge clock) begin
        if (rst || tk.restart) begin
            elapsed_reg <= 8'h00;
        end else if (tk.tick && elapsed_reg != 8'hff) begin
            elapsed_reg <= elapsed_reg + 8'h01;
        end
    end

    // phase length and slew mode captured at command time
    always_ff @(posedge clock) begin
        if (rst) begin
            target_reg <= 8'h00;
            slew_reg   <= 1'b0;
        end else if (take_on) begin
            target_reg <= turn_on_delay;
        end else if (take_off) begin
            slew_reg   <= ramp_rate_config[slew_ctrl_bit];
            target_reg <= ramp_rate_config[slew_ctrl_bit] ? pre_wait
                        : {2'b00, turn_off_delay_field};
        end
    end

    // sequencer state
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= st_off;
        end else if (take_off) begin
            state_reg <= st_off_wait;
        end else if (take_on) begin
            state_reg <= st_on_wait;
        end else begin
            unique case (state_reg)
                st_on_wait: if (expired) begin
                    state_reg <= st_on;
                end
                st_off_wait: if (expired) begin
                    // no slew: switches open, decay is the load's
                    state_reg <= slew_reg ? st_ramp_down
                                          : st_off;
                end
                st_ramp_down: if (vout_at_zero) begin
                    state_reg <= st_off;
                end
                default: ;  // off and on hold until a command
            endcase
        end
    end

    // start pulses to the slew generator
    always_ff @(posedge clock) begin
        if (rst) begin
            ramp_up_start   <= 1'b0;
            ramp_down_start <= 1'b0;
        end else begin
            ramp_up_start   <= !take_on && !take_off &&
                               state_reg == st_on_wait && expired;
            ramp_down_start <= !take_on && !take_off && slew_reg &&
                               state_reg == st_off_wait && expired;
        end
    end

    // regulation target with load-line droop, floored at zero
    always_ff @(posedge clock) begin
        if (rst) begin
            vout_target <= '0;
        end else begin
            vout_target <= (droop >= vset) ? '0 : vset - droop;
        end
    end

    // both switches open while off or still waiting to turn on
    assign switches_off = state_reg inside {st_off, st_on_wait};
    assign seq_busy     = state_reg inside {st_on_wait, st_off_wait,
                                            st_ramp_down};

    a_on_delay_end: assert property (@(posedge clock) disable iff (rst)
        state_reg == st_on_wait && expired && !take_on && !take_off
        |=> state_reg == st_on && ramp_up_start)
        else $error("turn-on delay did not end in ramp up");
    a_on_wait_hold: assert property (@(posedge clock) disable iff (rst)
        state_reg == st_on_wait && !expired && !turn_off_cmd
        && !turn_on_cmd |=> state_reg == st_on_wait)
        else $error("turn-on delay ended early");
    a_off_target: assert property (@(posedge clock) disable iff (rst)
        take_off && !ramp_rate_config[slew_ctrl_bit]
        |=> target_reg == {2'b00, $past(turn_off_delay_field)})
        else $error("turn-off delay not taken from register");
    a_read_upper: assert property (@(posedge clock) disable iff (rst)
        $past(reg_addr) == turn_off_delay_off
        |-> reg_rdata[7:6] == 2'b00)
        else $error("unimplemented bits read nonzero");
    a_ramp_zero: assert property (@(posedge clock) disable iff (rst)
        state_reg == st_ramp_down && vout_at_zero && !turn_on_cmd
        |=> state_reg == st_off && switches_off)
        else $error("ramp down did not end at zero");
    a_pre_wait: assert property (@(posedge clock) disable iff (rst)
        take_off && ramp_rate_config[slew_ctrl_bit]
        |=> (target_reg < {2'b00, $past(turn_off_delay_field)})
            || (target_reg == 8'h00))
        else $error("pre-ramp wait not shorter than delay");
    a_no_slew_off: assert property (@(posedge clock) disable iff (rst)
        state_reg == st_off_wait && expired && !slew_reg
        && !turn_on_cmd |=> switches_off && !ramp_down_start)
        else $error("switches not opened at delay end");
    a_droop: assert property (@(posedge clock) disable iff (rst)
        current_limit_setting[load_reg_lsb +: 4] == 4'h0
        |=> vout_target == $past(vset))
        else $error("output moved without load regulation");
    a_restart: assert property (@(posedge clock) disable iff (rst)
        take_on || take_off |=> elapsed_reg == 8'h00)
        else $error("delay counter not restarted");
    a_top_code: assert property (@(posedge clock) disable iff (rst)
        setpoint == 8'hff |-> vset == 14'h2af8)
        else $error("top setpoint decode wrong");

    c_turn_on: cover property (@(posedge clock) disable iff (rst)
        ramp_up_start);
    c_slew_off: cover property (@(posedge clock) disable iff (rst)
        ramp_down_start ##[1:1000] state_reg == st_off);
    c_hard_off: cover property (@(posedge clock) disable iff (rst)
        state_reg == st_off_wait && !slew_reg ##1 state_reg == st_off);
    c_restart: cover property (@(posedge clock) disable iff (rst)
        state_reg == st_on_wait && turn_on_cmd);
endmodule // output_turn_on_off_sequencer

// [seq_pkg.sv]
// constants for the output turn-on/turn-off sequencer
// assumes a 100 MHz device clock and a decoded register access port
package seq_pkg;
    // register offsets as seen by the bus manager
    localparam logic [7:0] ramp_rate_config_off      = 8'h03;
    localparam logic [7:0] turn_on_delay_off         = 8'h05;
    localparam logic [7:0] turn_off_delay_off        = 8'h06;
    localparam logic [7:0] setpoint_off              = 8'h07;
    localparam logic [7:0] current_limit_setting_off = 8'h08;
    // reset values (restored whenever power returns)
    localparam logic [7:0] ramp_rate_config_rst      = 8'h08;
    localparam logic [7:0] turn_on_delay_rst         = 8'h00;
    localparam logic [5:0] turn_off_delay_rst        = 6'h00;
    localparam logic [7:0] setpoint_rst              = 8'h00;
    localparam logic [7:0] current_limit_setting_rst = 8'h00;
    // field positions
    localparam int slew_ctrl_bit    = 3;  // falling slew control enable
    localparam int fall_rate_lsb    = 0;  // falling rate code, 3 bits
    localparam int load_reg_lsb     = 0;  // load-line slope, 4 bits
    localparam int off_field_w      = 6;  // implemented turn-off bits
    // setpoint decode, voltages in 0.5 mV units
    localparam int            vout_w      = 14;
    localparam logic [7:0]    sub1_last   = 8'h78;  // last 12.5 mV code
    localparam logic [7:0]    sub2_last   = 8'hfa;  // last 25 mV code
    localparam logic [13:0]   sub1_base   = 14'h03e8; // 0.500 V
    localparam logic [13:0]   sub2_base   = 14'h0fa0; // 2.000 V
    localparam logic [13:0]   sub3_base   = 14'h2904; // 5.250 V
    localparam logic [13:0]   step_fine   = 14'h0019; // 12.5 mV
    localparam logic [13:0]   step_mid    = 14'h0032; // 25 mV
    localparam logic [13:0]   step_coarse = 14'h0064; // 50 mV
    // timing
    localparam int clock_mhz   = 100;
    localparam int tick_us     = 1000;               // delay step, 1 ms
    localparam int tick_cycles = tick_us * clock_mhz;
    // falling rates in 0.5 mV per ms, codes 0..7
    localparam logic [14:0] fall_rate_tab [8] = '{
        15'h00c8, 15'h0190, 15'h03e8, 15'h07d0,
        15'h0fa0, 15'h2710, 15'h40d8, 15'h40d8};
    // sequencer states, one-hot
    typedef enum logic [4:0] {
        st_off       = 5'b00001,
        st_on_wait   = 5'b00010,
        st_on        = 5'b00100,
        st_off_wait  = 5'b01000,
        st_ramp_down = 5'b10000
    } seq_state_t;
endpackage

// [tick_if.sv]
// carrier between the sequencer and its millisecond tick divider
// assumes both ends share one clock
`timescale 1ns/1ps
interface tick_if;
    logic restart;  // clears the divider phase
    logic tick;     // one-cycle pulse every millisecond
    modport gen (input restart, output tick);
    modport use_tick (output restart, input tick);
endinterface

// [ms_tick_gen.sv]
// millisecond enable divider for the delay counters
// assumes restart comes from logic on the same clock
`timescale 1ns/1ps
module ms_tick_gen #(
    parameter int cycles = seq_pkg::tick_cycles
) (
    input  wire logic clock,
    input  wire logic rst,
    tick_if.gen       tk
);
    import seq_pkg::*;

    logic [16:0] div_reg;  // phase within the current millisecond

    // restart realigns the phase so a delay is a whole number of ms
    always_ff @(posedge clock) begin
        if (rst || tk.restart) begin
            div_reg <= '0;
        end else if (div_reg == 17'(cycles - 1)) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 17'h00001;
        end
    end

    // pulse on the last cycle of each millisecond
    assign tk.tick = (div_reg == 17'(cycles - 1)) && !tk.restart;

    a_tick_spacing: assert property (@(posedge clock) disable iff (rst)
        tk.restart |=> !tk.tick)
        else $error("tick right after restart");
endmodule // ms_tick_gen

// [output_stage_model.sv]
// behavioural power stage beside the sequencer: reports output at zero
// assumes ramp commands are one-cycle pulses on the shared clock
`timescale 1ns/1ps
module output_stage_model #(
    parameter int fall_cycles = 10
) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic ramp_up_start,
    input  wire logic ramp_down_start,
    output logic      vout_at_zero
);
    int count_reg;  // cycles left in the downward ramp

    // zero flag: low once ramped up, high again only after a full ramp down
    // without a commanded ramp the flag is left alone, decay is the load's
    always_ff @(posedge clock) begin
        if (rst) begin
            vout_at_zero <= 1'b1;
            count_reg    <= 0;
        end else if (ramp_up_start) begin
            vout_at_zero <= 1'b0;
            count_reg    <= 0;
        end else if (ramp_down_start) begin
            count_reg <= fall_cycles;
        end else if (count_reg == 1) begin
            vout_at_zero <= 1'b1;
            count_reg    <= 0;
        end else if (count_reg > 1) begin
            count_reg <= count_reg - 1;
        end
    end
endmodule  // output_stage_model

// [output_turn_on_off_sequencer_tb.sv]
// self-checking bench for the output turn-on/turn-off sequencer
// assumes a 10-cycle ms tick and the stage model driving the zero flag
`timescale 1ns/1ps
module output_turn_on_off_sequencer_tb;
    import seq_pkg::*;
    localparam int ms_n = 10;  // cycles per ms, shortened for simulation
    logic              clock        = 1'b0;
    logic              rst          = 1'b1;
    logic [7:0]        reg_addr     = 8'h00;
    logic [7:0]        reg_wdata    = 8'h00;
    logic              reg_wr       = 1'b0;
    logic              turn_on_cmd  = 1'b0;
    logic              turn_off_cmd = 1'b0;
    logic [7:0]        iout_meas    = 8'h00;
    logic [7:0]        reg_rdata;
    logic              vout_at_zero;
    logic [vout_w-1:0] vout_target;
    logic              ramp_up_start;
    logic              ramp_down_start;
    logic              switches_off;
    logic              seq_busy;
    int                downs        = 0;     // downward ramps seen
    int                fails        = 0;
    int                comparisons  = 0;
    int                n1;
    int                n2;
    logic [7:0]        rd_val;
    // scenario tables: addresses, write data, setpoints and delays
    logic [7:0]        ra [6] = '{8'h03, 8'h05, 8'h06, 8'h07, 8'h08, 8'h20};
    logic [7:0]        rx [6] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0]        wd [4] = '{8'hff, 8'hff, 8'h05, 8'haa};
    logic [7:0]        wx [4] = '{8'hff, 8'h3f, 8'h05, 8'h00};
    logic [7:0]        vc [7] = '{8'h00, 8'h01, 8'h78, 8'h79, 8'hfa,
                                  8'hfb, 8'hff};
    logic [13:0]       vx [7] = '{14'd1000, 14'd1025, 14'd4000, 14'd4050,
                                  14'd10500, 14'd10600, 14'd11000};
    int                d [3]  = '{0, 1, 3};

    output_turn_on_off_sequencer #(.ms_cycles(ms_n)) dut (
        .clock(clock), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
        .turn_on_cmd(turn_on_cmd), .turn_off_cmd(turn_off_cmd),
        .iout_meas(iout_meas), .vout_at_zero(vout_at_zero),
        .vout_target(vout_target), .ramp_up_start(ramp_up_start),
        .ramp_down_start(ramp_down_start), .switches_off(switches_off),
        .seq_busy(seq_busy));

    output_stage_model #(.fall_cycles(ms_n)) stage (
        .clock(clock), .rst(rst), .ramp_up_start(ramp_up_start),
        .ramp_down_start(ramp_down_start), .vout_at_zero(vout_at_zero));

    // free-running 100 MHz clock
    initial begin
        forever #5 clock = ~clock;
    end

    // counts downward ramps so the no-slew path can be judged
    always @(posedge clock) begin
        if (ramp_down_start === 1'b1) begin
            downs <= downs + 1;
        end
    end

    // compare tasks, one per kind of result
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask
    task automatic check_vout(input logic [13:0] got, input logic [13:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask
    task automatic check_count(input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h..%h", $time,
                     got, lo, hi);
        end
    endtask

    // register port: strobe held for one edge, read data one cycle later
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        @(negedge clock);
        d = reg_rdata;
    endtask

    // one-cycle command pulse; returns just after the accepting edge
    task automatic cmd(input logic on);
        @(negedge clock);
        turn_on_cmd  = on;
        turn_off_cmd = ~on;
        @(negedge clock);
        turn_on_cmd  = 1'b0;
        turn_off_cmd = 1'b0;
    endtask

    function automatic logic pick(input int which);
        case (which)
            0: pick = ramp_up_start;
            1: pick = ramp_down_start;
            default: pick = switches_off;
        endcase
    endfunction
    // cycles until the chosen output is high, bounded
    task automatic wait_for(input int which, output int n);
        n = 0;
        while (pick(which) !== 1'b1 && n < 4000) begin
            @(negedge clock);
            n++;
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // hang guard, well beyond the fewer than 1000 cycles the tests need
    initial begin
        repeat (30000) @(posedge clock);
        fails++;
        $display("watchdog expired at %0t", $time);
        tally_and_finish();
    end

    // main sequence
    initial begin  // one converter alone, never margined
        repeat (4) @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        // defaults, unmapped place reads zero
        for (int i = 0; i < 6; i++) begin
            rd(ra[i], rd_val);
            check_byte(rd_val, rx[i]);
        end
        check_vout(vout_target, 14'd1000);
        $display("test reset_defaults done");
        // write and read back; upper turn-off bits and unmapped stay zero
        for (int i = 0; i < 4; i++) begin
            wr(ra[i + 1 - (i / 3) * 3 + (i / 3) * 4], wd[i]);
            rd(ra[i + 1 - (i / 3) * 3 + (i / 3) * 4], rd_val);
            check_byte(rd_val, wx[i]);
        end
        rd(8'h06, rd_val);
        check_byte(rd_val, 8'h3f);
        $display("test register_access done");
        // setpoint decode across all three sub-ranges and the ends
        for (int i = 0; i < 7; i++) begin
            wr(setpoint_off, vc[i]);
            repeat (3) @(negedge clock);
            check_vout(vout_target, vx[i]);
        end
        // load line: 2.000 V minus 20 * 3 half-millivolts
        wr(setpoint_off, 8'h78);
        wr(current_limit_setting_off, 8'h03);
        iout_meas = 8'd20;
        repeat (3) @(negedge clock);
        check_vout(vout_target, 14'd3940);
        iout_meas = 8'd0;
        wr(current_limit_setting_off, 8'h00);
        $display("test setpoint_decode done");
        // turn-on delays without slew, turn-off delay zero
        wr(ramp_rate_config_off, 8'h00);
        wr(turn_off_delay_off, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wr(turn_on_delay_off, d[i][7:0]);
            cmd(1'b1);
            wait_for(0, n1);
            check_count(n1, d[i] * ms_n + 1, d[i] * ms_n + 2);
            @(negedge clock);
            check_byte({7'h00, switches_off}, 8'h00);
            cmd(1'b0);
            wait_for(2, n2);
            check_count(n2, 1, 3);
        end
        // a second turn-on in mid-wait restarts the count
        cmd(1'b1);
        repeat (15) @(negedge clock);
        check_byte({7'h00, seq_busy}, 8'h01);
        cmd(1'b1);
        wait_for(0, n1);
        check_count(n1, 3 * ms_n + 1, 3 * ms_n + 2);
        $display("test turn_on_delay done");
        // longest turn-off delay, no slew: switches drop, no ramp
        wr(turn_off_delay_off, 8'h3f);
        n1 = downs;
        cmd(1'b0);
        wait_for(2, n2);
        check_count(n2, 63 * ms_n + 1, 63 * ms_n + 3);
        check_count(downs - n1, 0, 0);
        // turn-off while already off is ignored
        cmd(1'b0);
        repeat (5) @(negedge clock);
        check_byte({6'h00, seq_busy, switches_off}, 8'h01);
        $display("test turn_off_plain done");
        // slew at 2 V/ms from 2.000 V: 1 ms ramp inside a 3 ms delay,
        // chosen so the pre-ramp wait stays positive
        wr(ramp_rate_config_off, 8'h0c);
        wr(turn_off_delay_off, 8'h03);
        wr(turn_on_delay_off, 8'h00);
        cmd(1'b1);
        wait_for(0, n1);
        cmd(1'b0);
        wait_for(1, n1);
        check_count(n1, 2 * ms_n + 1, 2 * ms_n + 3);
        wait_for(2, n2);
        check_count(n2, ms_n, ms_n + 3);
        check_count(n1 + n2, 3 * ms_n, 3 * ms_n + 6);
        $display("test turn_off_slew done");
        tally_and_finish();
    end
endmodule  // output_turn_on_off_sequencer_tb
